// ---- atx_ctl_pkg.sv ----
// Constants, register map and types for the host power and reset controller
package atx_ctl_pkg;

  // Clock and time base
  localparam int CLK_HZ          = 20_000_000;
  localparam int TICK_US         = 31_250;
  localparam int TICK_CYCLES_DEF = TICK_US * (CLK_HZ / 1_000_000);

  // Times as documented, in milliseconds
  localparam int HOLD_ON_MS   = 250;
  localparam int HOLD_LONG_MS = 4000;
  localparam int EXTEND_MS    = 5000;
  localparam int RESET_MS     = 1000;
  localparam int PULSE_DEF_MS = 1000;

  // Times converted to ticks of the time base
  localparam logic [7:0] HOLD_ON_TICKS   = 8'((HOLD_ON_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [7:0] HOLD_LONG_TICKS = 8'((HOLD_LONG_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [7:0] EXTEND_TICKS    = 8'((EXTEND_MS * 1000) / TICK_US);
  localparam logic [7:0] RESET_TICKS     = 8'((RESET_MS * 1000 + TICK_US - 1) / TICK_US);
  localparam logic [7:0] PULSE_DEF_TICKS = 8'((PULSE_DEF_MS * 1000) / TICK_US);

  // Register byte addresses
  localparam logic [3:0] ADDR_ENABLE  = 4'h0;
  localparam logic [3:0] ADDR_PULSE   = 4'h4;
  localparam logic [3:0] ADDR_COMMAND = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hC;

  // Enable register fields
  localparam int EN_AUTO_POL = 0;
  localparam int EN_RST_INV  = 1;
  localparam int EN_PWR_INV  = 2;
  localparam int EN_BLANK    = 4;
  localparam int EN_RESET    = 5;
  localparam int EN_PWR_ON   = 6;
  localparam int EN_PWR_OFF  = 7;

  // Reset values
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PULSE_RST  = PULSE_DEF_TICKS;
  localparam logic [7:0] REPLY_RST  = 8'h00;

  // Command packet fields
  localparam int         CMD_TYPE_LSB = 6;
  localparam int         CMD_LEN_LSB  = 8;
  localparam logic [1:0] TYPE_CMD     = 2'h0;
  localparam logic [1:0] TYPE_RESP    = 2'h1;
  localparam logic [1:0] TYPE_ERR     = 2'h3;
  localparam logic [5:0] CODE_SAVE    = 6'h04;
  localparam logic [7:0] LEN_MAX      = 8'h12;

  // Status register fields
  localparam int ST_SENSE   = 0;
  localparam int ST_PWR_DRV = 1;
  localparam int ST_RST_DRV = 2;
  localparam int ST_BLANK   = 3;
  localparam int ST_CMD_ERR = 4;
  localparam int ST_SAVED   = 5;
  localparam int ST_REPLY   = 8;

  typedef enum logic [2:0] {
    S_IDLE,
    S_PWR_PULSE,
    S_PWR_EXTEND,
    S_RST_PULSE,
    S_RESTART
  } seq_e;

endpackage

// ---- hold_if.sv ----
// Carrier between the controller and its key hold timers
`timescale 1ns/1ps
interface hold_if;
  logic       tick;
  logic       key;
  logic [7:0] held;
  modport timer (input tick, input key, output held);
  modport user  (output tick, output key, input held);
endinterface

// ---- key_hold_timer.sv ----
// Counts how long a synchronised key has been held, in time-base ticks
`timescale 1ns/1ps
module key_hold_timer
  import atx_ctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  hold_if.timer    hb
);

  typedef struct packed {
    logic [7:0] cnt;
  } timer_s;

  timer_s s_r;
  timer_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!hb.key) begin
      s_nxt.cnt = 8'h00; // RULE_13
    end else if (hb.tick && s_r.cnt != 8'hFF) begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hb.held = s_r.cnt;

endmodule

// ---- atx_host_power_reset_control.sv ----
// Host power and reset sequencer with keypad hold detection and register port
//
// Summary of operation
// RULE_01 - Power line floats, drives briefly, chosen polarity
// RULE_02 - Reset line floats, drives briefly, chosen polarity
// RULE_03 - Host off, confirm 0.25 s: power pulse
// RULE_04 - Host on, cancel 4 s: forced power-off pulse
// RULE_05 - Held cancel extends drive up to 5 s
// RULE_06 - Host on, confirm 4 s: 1 s reset
// RULE_07 - Restart self right after host reset
// RULE_08 - Blank display while host off, if enabled
// RULE_09 - Each function acts only when enabled
// RULE_10 - Configurer keeps control pins out of user use
// RULE_11 - Enable 241: five functions; 16: half-second pulse
// RULE_12 - Zero-length code 4 saves configuration for power-up
// RULE_13 - Release restarts hold timer; one pulse per press
// RULE_14 - Type byte: two type bits, six code bits
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module atx_host_power_reset_control
  import atx_ctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        confirmKey,
  input  wire logic        cancelKey,
  input  wire logic        hostPowerSense,
  input  wire logic        powerIn,
  output logic             powerOut,
  output logic             powerOeN,
  input  wire logic        resetIn,
  output logic             resetOut,
  output logic             resetOeN,
  output logic             displayBlank,
  output logic             selfRestart
);

  typedef struct packed {
    logic [1:0]  confSy;
    logic [1:0]  cancSy;
    logic [1:0]  senseSy;
    logic [1:0]  pwrSy;
    logic [1:0]  rstSy;
    logic [19:0] pre;
    logic        tick;
    seq_e        seq;
    logic [7:0]  cnt;
    logic        forced;
    logic        confFired;
    logic        cancFired;
    logic [7:0]  enable;
    logic [7:0]  pulse;
    logic [7:0]  savedEnable;
    logic [7:0]  savedPulse;
    logic        saved;
    logic        cmdErr;
    logic [7:0]  reply;
    logic        pwrIdle;
    logic        rstIdle;
    logic        pwrDrive;
    logic        rstDrive;
    logic        pwrLevel;
    logic        rstLevel;
    logic        blank;
    logic        restart;
    logic        ack;
    logic [31:0] rdata;
  } ctl_s;

  localparam ctl_s CTL_RST = '{
    confSy:      2'h0,
    cancSy:      2'h0,
    senseSy:     2'h0,
    pwrSy:       2'h3,
    rstSy:       2'h3,
    pre:         20'h00000,
    tick:        1'b0,
    seq:         S_IDLE,
    cnt:         8'h00,
    forced:      1'b0,
    confFired:   1'b0,
    cancFired:   1'b0,
    enable:      ENABLE_RST,
    pulse:       PULSE_RST,
    savedEnable: ENABLE_RST,
    savedPulse:  PULSE_RST,
    saved:       1'b0,
    cmdErr:      1'b0,
    reply:       REPLY_RST,
    pwrIdle:     1'b1,
    rstIdle:     1'b1,
    pwrDrive:    1'b0,
    rstDrive:    1'b0,
    pwrLevel:    1'b0,
    rstLevel:    1'b0,
    blank:       1'b0,
    restart:     1'b0,
    ack:         1'b0,
    rdata:       32'h00000000
  };

  ctl_s s_r;
  ctl_s s_nxt;

  hold_if confIf ();
  hold_if cancIf ();

  assign confIf.tick = s_r.tick;
  assign confIf.key  = s_r.confSy[1];
  assign cancIf.tick = s_r.tick;
  assign cancIf.key  = s_r.cancSy[1];

  key_hold_timer u_conf_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .hb      (confIf)
  );

  key_hold_timer u_canc_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .hb      (cancIf)
  );

  // Drive level: auto polarity opposes the level the line rests at
  function automatic logic drive_level(input logic auto, input logic inv, input logic idle);
    drive_level = auto ? ~idle : inv;
  endfunction

  logic        busReq;
  logic        wrAcc;
  logic        sense;
  logic        cmdOk;
  logic [1:0]  cmdType;
  logic [5:0]  cmdCode;
  logic [7:0]  cmdLen;

  assign busReq      = read | write;
  assign waitrequest = busReq & ~s_r.ack;
  assign wrAcc       = write & s_r.ack;
  assign sense       = s_r.senseSy[1];
  assign cmdType     = writedata[CMD_TYPE_LSB +: 2];
  assign cmdCode     = writedata[5:0];
  assign cmdLen      = writedata[CMD_LEN_LSB +: 8];
  assign cmdOk       = (cmdType == TYPE_CMD) && (cmdLen <= LEN_MAX) // RULE_14
                       && (cmdCode == CODE_SAVE) && (cmdLen == 8'h00); // RULE_12

  always_comb begin
    s_nxt = s_r;

    // Pins from outside pass two flip-flops
    s_nxt.confSy  = {s_r.confSy[0], confirmKey};
    s_nxt.cancSy  = {s_r.cancSy[0], cancelKey};
    s_nxt.senseSy = {s_r.senseSy[0], hostPowerSense};
    s_nxt.pwrSy   = {s_r.pwrSy[0], powerIn};
    s_nxt.rstSy   = {s_r.rstSy[0], resetIn};

    // Time base
    s_nxt.tick = 1'b0;
    if (s_r.pre == 20'(TICK_CYCLES - 1)) begin
      s_nxt.pre  = 20'h00000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.pre = s_r.pre + 20'h00001;
    end

    // A press fires once; release re-arms it
    if (!s_r.confSy[1]) begin
      s_nxt.confFired = 1'b0; // RULE_13
    end
    if (!s_r.cancSy[1]) begin
      s_nxt.cancFired = 1'b0; // RULE_13
    end

    if (s_r.tick) begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
    s_nxt.restart = 1'b0;

    unique case (s_r.seq)
      S_IDLE: begin
        s_nxt.cnt    = 8'h00;
        s_nxt.forced = 1'b0;
        if (!sense && s_r.enable[EN_PWR_ON] && !s_r.confFired // RULE_09
            && confIf.held >= HOLD_ON_TICKS) begin
          s_nxt.seq       = S_PWR_PULSE; // RULE_03
          s_nxt.confFired = 1'b1;
        end else if (sense && s_r.enable[EN_PWR_OFF] && !s_r.cancFired // RULE_09
                     && cancIf.held >= HOLD_LONG_TICKS) begin
          s_nxt.seq       = S_PWR_PULSE; // RULE_04
          s_nxt.forced    = 1'b1;
          s_nxt.cancFired = 1'b1;
        end else if (sense && s_r.enable[EN_RESET] && !s_r.confFired // RULE_09
                     && confIf.held >= HOLD_LONG_TICKS) begin
          s_nxt.seq       = S_RST_PULSE; // RULE_06
          s_nxt.confFired = 1'b1;
        end
      end
      S_PWR_PULSE: begin
        if (s_r.cnt >= s_r.pulse) begin
          s_nxt.cnt = 8'h00;
          s_nxt.seq = (s_r.forced && s_r.cancSy[1]) ? S_PWR_EXTEND : S_IDLE; // RULE_05
        end
      end
      S_PWR_EXTEND: begin
        // Extension stops at release or at its ceiling, whichever is first
        if (!s_r.cancSy[1] || s_r.cnt >= EXTEND_TICKS) begin
          s_nxt.seq = S_IDLE; // RULE_05
        end
      end
      S_RST_PULSE: begin
        if (s_r.cnt >= RESET_TICKS) begin
          s_nxt.seq = S_RESTART; // RULE_06
        end
      end
      S_RESTART: begin
        // Self restart reloads the stored power-up configuration
        s_nxt.enable  = s_r.savedEnable; // RULE_07
        s_nxt.pulse   = s_r.savedPulse; // RULE_12
        s_nxt.restart = 1'b1; // RULE_07
        s_nxt.seq     = S_IDLE;
      end
    endcase

    // Time base restarts as a pulse starts, else widths could fall short by a tick
    if (s_r.seq == S_IDLE && s_nxt.seq != S_IDLE) begin
      s_nxt.pre  = 20'h00000; // RULE_06
      s_nxt.tick = 1'b0;
    end

    // Lines float except during their pulses
    s_nxt.pwrDrive = (s_nxt.seq == S_PWR_PULSE) || (s_nxt.seq == S_PWR_EXTEND); // RULE_01
    s_nxt.rstDrive = (s_nxt.seq == S_RST_PULSE); // RULE_02
    if (!s_r.pwrDrive) begin
      s_nxt.pwrIdle = s_r.pwrSy[1];
    end
    if (!s_r.rstDrive) begin
      s_nxt.rstIdle = s_r.rstSy[1];
    end
    // Polarity is held steady while a line is driven
    if (!s_r.pwrDrive) begin
      s_nxt.pwrLevel = drive_level(s_r.enable[EN_AUTO_POL], s_r.enable[EN_PWR_INV],
                                   s_r.pwrIdle); // RULE_01
    end
    if (!s_r.rstDrive) begin
      s_nxt.rstLevel = drive_level(s_r.enable[EN_AUTO_POL], s_r.enable[EN_RST_INV],
                                   s_r.rstIdle); // RULE_02
    end

    s_nxt.blank = s_r.enable[EN_BLANK] && !sense; // RULE_08

    // Bus slave: one wait state, then the access completes
    s_nxt.ack = busReq && !s_r.ack;
    if (read && !s_r.ack) begin
      unique case (address)
        ADDR_ENABLE:  s_nxt.rdata = {24'h000000, s_r.enable};
        ADDR_PULSE:   s_nxt.rdata = {24'h000000, s_r.pulse};
        ADDR_COMMAND: s_nxt.rdata = {24'h000000, s_r.reply};
        ADDR_STATUS: begin
          s_nxt.rdata               = 32'h00000000;
          s_nxt.rdata[ST_SENSE]     = sense;
          s_nxt.rdata[ST_PWR_DRV]   = s_r.pwrDrive;
          s_nxt.rdata[ST_RST_DRV]   = s_r.rstDrive;
          s_nxt.rdata[ST_BLANK]     = s_r.blank;
          s_nxt.rdata[ST_CMD_ERR]   = s_r.cmdErr;
          s_nxt.rdata[ST_SAVED]     = s_r.saved;
          s_nxt.rdata[ST_REPLY +: 8] = s_r.reply;
        end
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end

    if (wrAcc && byteenable[0]) begin
      unique case (address)
        ADDR_ENABLE: s_nxt.enable = writedata[7:0]; // RULE_11
        ADDR_PULSE:  s_nxt.pulse  = writedata[7:0]; // RULE_11
        ADDR_STATUS: begin
          if (writedata[ST_CMD_ERR]) begin
            s_nxt.cmdErr = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Commands need both low lanes so type and length arrive together
    if (wrAcc && address == ADDR_COMMAND && byteenable[1:0] == 2'h3) begin
      if (cmdOk) begin
        s_nxt.savedEnable = s_r.enable; // RULE_12
        s_nxt.savedPulse  = s_r.pulse;
        s_nxt.saved       = 1'b1;
        s_nxt.reply       = {TYPE_RESP, cmdCode}; // RULE_14
      end else begin
        s_nxt.cmdErr = 1'b1;
        s_nxt.reply  = {TYPE_ERR, cmdCode}; // RULE_14
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= CTL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign readdata     = s_r.rdata;
  assign powerOut     = s_r.pwrLevel;
  assign powerOeN     = ~s_r.pwrDrive;
  assign resetOut     = s_r.rstLevel;
  assign resetOeN     = ~s_r.rstDrive;
  assign displayBlank = s_r.blank;
  assign selfRestart  = s_r.restart;

endmodule

// ---- atx_ctl_assertions.sv ----
// Port-level checks for the host power and reset controller
`timescale 1ns/1ps
module atx_ctl_assertions
  import atx_ctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic confirmKey,
  input wire logic cancelKey,
  input wire logic powerOut,
  input wire logic powerOeN,
  input wire logic resetOut,
  input wire logic resetOeN,
  input wire logic hostPowerSense,
  input wire logic displayBlank,
  input wire logic selfRestart
);
  int pwrCnt_r;
  int rstCnt_r;
  int idleCnt_r;
  // Counters, so that long pulses need no unrolled repetition
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwrCnt_r <= 0;
      rstCnt_r <= 0;
      idleCnt_r <= 0;
    end else begin
      pwrCnt_r <= powerOeN ? 0 : pwrCnt_r + 1;
      rstCnt_r <= resetOeN ? 0 : rstCnt_r + 1;
      idleCnt_r <= (confirmKey || cancelKey) ? 0 : (idleCnt_r < 8 ? idleCnt_r + 1 : 8);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_pwr_lvl; !powerOeN && !$past(powerOeN) |-> $stable(powerOut); endproperty
  property p_rst_lvl; !resetOeN && !$past(resetOeN) |-> $stable(resetOut); endproperty
  property p_pwr_cause; $fell(powerOeN) |-> idleCnt_r < 8; endproperty
  property p_rst_cause; $fell(resetOeN) |-> idleCnt_r < 8 && !cancelKey; endproperty
  property p_rst_len;
    $rose(resetOeN) && !$past(rst) |->
      rstCnt_r >= 32 * TICK_CYCLES - 2 && rstCnt_r <= 34 * TICK_CYCLES;
  endproperty
  property p_pwr_max; pwrCnt_r <= 420 * TICK_CYCLES; endproperty
  property p_restart; $rose(resetOeN) && !$past(rst) |-> ##[0:3] selfRestart; endproperty
  property p_blank; hostPowerSense [*5] |=> !displayBlank; endproperty
  property p_one_drive; !(!powerOeN && !resetOeN); endproperty
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_pwr_lvl: assert property (p_pwr_lvl) else $error("power level moved");
  a_rst_lvl: assert property (p_rst_lvl) else $error("reset level moved");
  a_pwr_cause: assert property (p_pwr_cause) else $error("power drive, no key");
  a_rst_cause: assert property (p_rst_cause) else $error("reset drive, no key");
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
  a_pwr_max: assert property (p_pwr_max) else $error("power drive too long");
  a_restart: assert property (p_restart) else $error("no restart");
  a_blank: assert property (p_blank) else $error("blank with host on");
  a_one_drive: assert property (p_one_drive) else $error("two drives");
  a_wait: assert property (p_wait) else $error("wait state count");
  c_pwr: cover property ($fell(powerOeN));
  c_rst: cover property ($fell(resetOeN));
  c_restart: cover property (selfRestart);
  c_blank: cover property ($rose(displayBlank));
endmodule
bind atx_host_power_reset_control atx_ctl_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
  .confirmKey(confirmKey), .cancelKey(cancelKey), .powerOut(powerOut),
  .powerOeN(powerOeN), .resetOut(resetOut), .resetOeN(resetOeN),
  .hostPowerSense(hostPowerSense), .displayBlank(displayBlank), .selfRestart(selfRestart));

// ---- atx_board_model.sv ----
// Motherboard side: pulled-up switch inputs and a host supply latch
`timescale 1ns/1ps
module atx_board_model #(
  parameter int DELAY = 16
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic powerOut,
  input  wire logic powerOeN,
  input  wire logic resetOut,
  input  wire logic resetOeN,
  output logic      powerIn,
  output logic      resetIn,
  output logic      hostPowerSense
);
  logic pressed_r;
  int   dly_r;
  // Floating lines read high through the board pull-ups
  assign powerIn = powerOeN ? 1'b1 : powerOut;
  assign resetIn = resetOeN ? 1'b1 : resetOut;
  // Supply toggles DELAY cycles after a low press ends, as a slow board would
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pressed_r <= 1'b0;
      dly_r <= 0;
      hostPowerSense <= 1'b0;
    end else begin
      pressed_r <= !powerIn;
      dly_r <= (pressed_r && powerIn) ? DELAY : (dly_r > 0 ? dly_r - 1 : 0);
      if (dly_r == 1) hostPowerSense <= !hostPowerSense;
    end
  end
endmodule

// ---- atx_host_power_reset_control_tb.sv ----
// Self-checking bench for the host power and reset controller
`timescale 1ns/1ps
module atx_host_power_reset_control_tb
  import atx_ctl_pkg::*;
;
  localparam int T = 4;
  logic        sys_clk, rst, read, write, waitrequest, confirmKey, cancelKey;
  logic        powerIn, powerOut, powerOeN, resetIn, resetOut, resetOeN;
  logic        hostPowerSense, displayBlank, selfRestart, lvl, restartSeen;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, lfsr, q;
  int          failures, samples_checked, n, pw, h;
  atx_host_power_reset_control #(.TICK_CYCLES(T)) DUT (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .confirmKey(confirmKey), .cancelKey(cancelKey),
    .hostPowerSense(hostPowerSense), .powerIn(powerIn), .powerOut(powerOut),
    .powerOeN(powerOeN), .resetIn(resetIn), .resetOut(resetOut), .resetOeN(resetOeN),
    .displayBlank(displayBlank), .selfRestart(selfRestart));
  atx_board_model #(.DELAY(16)) board (
    .sys_clk(sys_clk), .rst(rst), .powerOut(powerOut), .powerOeN(powerOeN),
    .resetOut(resetOut), .resetOeN(resetOeN), .powerIn(powerIn), .resetIn(resetIn),
    .hostPowerSense(hostPowerSense));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (selfRestart === 1'b1) restartSeen <= 1'b1;
  function int rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return int'(lfsr[15:0]);
  endfunction
  function logic [31:0] reply(input logic [1:0] ty, input logic [7:0] ln);
    return {24'h0, (ty == TYPE_CMD && ln == 8'h0) ? TYPE_RESP : TYPE_ERR, CODE_SAVE};
  endfunction
  task stop_test();
    $display("Checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    byteenable <= 4'hF;
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rdchk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(q & m, e & m);
  endtask
  task press(input logic c, input int ticks);
    @(posedge sys_clk);
    confirmKey <= c;
    cancelKey <= !c;
    repeat (ticks * T) @(posedge sys_clk);
    confirmKey <= 1'b0;
    cancelKey <= 1'b0;
  endtask
  // Waits for a drive to start, then counts its cycles; n stays 0 if none came
  task drive(input logic p, input int lim);
    n = 0;
    repeat (lim) begin
      @(posedge sys_clk);
      if ((p ? powerOeN : resetOeN) === 1'b0) break;
    end
    lvl = p ? powerOut : resetOut;
    while ((p ? powerOeN : resetOeN) === 1'b0 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
  initial begin
    {rst, read, write, confirmKey, cancelKey, restartSeen} = 6'h20;
    {address, byteenable, writedata} = '0;
    lfsr = 32'h8889;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk(ADDR_ENABLE, {24'h0, ENABLE_RST}, 32'hFF);
    rdchk(ADDR_PULSE, {24'h0, PULSE_RST}, 32'hFF);
    rdchk(4'h2, 32'h0, 32'hFFFF_FFFF);
    fork
      press(1'b1, 12);
      drive(1'b1, 20 * T);
    join
    chk(32'(n), 32'h0);
    chk(displayBlank, 32'h0);
    $display("Test disabled finished");
    pw = 8 + rnd() % 16;
    bus(1'b1, ADDR_ENABLE, 32'd241);
    bus(1'b1, ADDR_PULSE, 32'(pw));
    rdchk(ADDR_ENABLE, 32'd241, 32'hFF);
    chk(displayBlank, 32'h1);
    fork
      press(1'b1, pw + 160);
      begin
        drive(1'b1, 40 * T);
        chk(lvl, 32'h0);
        rng(n, pw * T, (pw + 2) * T);
        drive(1'b1, 140 * T);
        chk(32'(n), 32'h0);
      end
    join
    chk(displayBlank, 32'h0);
    $display("Test power-on finished");
    for (int i = 4; i >= 0; i--) begin
      bus(1'b1, ADDR_COMMAND, {16'h0, i == 4 ? 8'h13 : 8'h0, i[1:0], CODE_SAVE});
      rdchk(ADDR_COMMAND, reply(i[1:0], i == 4 ? 8'h13 : 8'h0), 32'hFF);
    end
    rdchk(ADDR_STATUS, 32'h31, 32'h31);
    bus(1'b1, ADDR_STATUS, 32'h10);
    rdchk(ADDR_STATUS, 32'h0, 32'h10);
    $display("Test command finished");
    h = 60 + rnd() % 60;
    fork
      begin
        press(1'b1, h);
        repeat (2 * T) @(posedge sys_clk);
        press(1'b1, h);
      end
      drive(1'b0, (2 * h + 4) * T);
    join
    chk(32'(n), 32'h0);
    bus(1'b1, ADDR_PULSE, 32'(pw + 1));
    restartSeen = 1'b0;
    fork
      press(1'b1, 140);
      drive(1'b0, 150 * T);
    join
    repeat (4) @(posedge sys_clk);
    chk(lvl, 32'h0);
    rng(n, 32 * T, 34 * T);
    chk(restartSeen, 32'h1);
    rdchk(ADDR_ENABLE, 32'd241, 32'hFF);
    rdchk(ADDR_PULSE, 32'(pw), 32'hFF);
    $display("Test reset finished");
    bus(1'b1, ADDR_ENABLE, 32'hF4);
    fork
      press(1'b0, 400);
      drive(1'b1, 200 * T);
    join
    chk(lvl, 32'h1);
    rng(n, pw * T, (pw + 162) * T);
    $display("Test forced-off finished");
    stop_test();
  end
endmodule
